// ### dma_cycle_pkg.sv
// shared constants and types for the cycle-steal transfer controller
package dma_cycle_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int CH_COUNT = 4;
	localparam int CH_W = 2;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int CNT_W = 16;
	localparam int CAUSE_W = 2;
	localparam int CYC_W = 3;
	localparam int BUF_DEPTH = 16;

	// ****************************************
	// request cause encodings
	// ****************************************
	localparam logic [CAUSE_W-1:0] CAUSE_PERIPH = 2'h0;
	localparam logic [CAUSE_W-1:0] CAUSE_SOFT = 2'h1;
	localparam logic [CAUSE_W-1:0] CAUSE_EXT_FALL = 2'h2;
	localparam logic [CAUSE_W-1:0] CAUSE_EXT_BOTH = 2'h3;

	// ****************************************
	// bus cycle coefficients (in clock cycles)
	// ****************************************
	localparam logic [CYC_W-1:0] COEF_BASE = 3'h1;
	localparam logic [CYC_W-1:0] COEF_SFR = 3'h2;
	localparam logic [CYC_W-1:0] COEF_EXT_WRITE = 3'h2;
	localparam logic [CYC_W-1:0] CYC_ONE = 3'h1;

	// ****************************************
	// address steps, counter and reset values
	// ****************************************
	localparam logic [ADDR_W-1:0] STEP_BYTE = 20'h0_0001;
	localparam logic [ADDR_W-1:0] STEP_WORD = 20'h0_0002;
	localparam logic [ADDR_W-1:0] ADDR_RST = 20'h0_0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam int BYTE_W = 8;

	// ****************************************
	// sequencer states
	// ****************************************
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_READ = 4'b0010,
		ST_WRITE = 4'b0100,
		ST_CPU = 4'b1000
	} seq_state_t;

endpackage

// ### dma_unit_fifo.sv
// word buffer between source read and destination write
`timescale 1ns/1ps
module dma_unit_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PTR_W = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
			$error("fifo depth must be a power of two, at least 2");
		end
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [PTR_W:0] level, next_level;
	logic push, pop;

	always_comb begin
		in_ready = (level != DEPTH[PTR_W:0]);
		out_valid = (level != '0);
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_level = level;
		if (push && !pop) begin
			next_level = level + 1'b1;
		end else if (pop && !push) begin
			next_level = level - 1'b1;
		end
		out_data = mem[rd_ptr];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			level <= next_level;
		end
	end

	// storage has no reset; level guards every read
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

endmodule

// ### dma_request_priority_cycle_control.sv
// four-channel cycle-steal transfer controller: requests, priority, bus cycles
//
// Operation
// - writing one to enable activates channel; pending requests then start transfers
// - first transfer after activation loads forward pointer from incrementing side
// - first transfer after activation loads counter from reload value
// - writing one while active restarts channel, repeating both reloads
// - each channel takes its request from one selected cause
// - request flag sets on selected event regardless of enable
// - request flag clears just before its transfer begins
// - software clear writes zero the flag; writing one does nothing
// - peripheral cause sets flag together with the peripheral interrupt
// - external cause sets flag on the chosen pin edge
// - requests in one clock cycle set all affected flags together
// - channel zero has highest priority, then one, two, three
// - after each transfer the CPU gets one bus access
// - a transfer is source reads followed by destination writes
// - odd address 16-bit unit on 16-bit bus takes two accesses
// - narrow external bus moves a 16-bit unit as two bytes
// - controller uses bus width pin width for internal areas too
// - special function area or waited region adds bus cycles
// - unit cycles are reads times j plus writes times k
// - single mode underflow clears enable and stops channel
// - repeat mode underflow keeps channel active and reloads
`timescale 1ns/1ps
module dma_request_priority_cycle_control
	import dma_cycle_pkg::*;
#(
	parameter int NUM_CH = CH_COUNT,
	parameter int FIFO_DEPTH = BUF_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// software writes to channel control
	input wire logic [NUM_CH-1:0] enable_write,
	input wire logic [NUM_CH-1:0] enable_wdata,
	input wire logic [NUM_CH-1:0] req_clear,
	// channel configuration
	input wire logic [NUM_CH-1:0][CAUSE_W-1:0] channel_cause_select,
	input wire logic [NUM_CH-1:0] repeat_mode,
	input wire logic [NUM_CH-1:0] unit_16,
	input wire logic [NUM_CH-1:0] fwd_is_src,
	input wire logic [NUM_CH-1:0][ADDR_W-1:0] src_ptr,
	input wire logic [NUM_CH-1:0][ADDR_W-1:0] dst_ptr,
	input wire logic [NUM_CH-1:0][CNT_W-1:0] count_reload,
	// request sources
	input wire logic [NUM_CH-1:0] periph_irq,
	input wire logic [NUM_CH-1:0] sw_req,
	input wire logic [NUM_CH-1:0] external_irq_pin,
	// bus environment
	input wire logic ext_bus_mode,
	input wire logic byte_pin,
	input wire logic region_sfr,
	input wire logic region_ext,
	input wire logic [1:0] region_waits,
	input wire logic cpu_access_done,
	// bus master side
	output logic bus_own,
	output logic [ADDR_W-1:0] bus_addr,
	output logic bus_rd,
	output logic bus_wr,
	output logic bus_byte,
	output logic [DATA_W-1:0] bus_wdata,
	input wire logic [DATA_W-1:0] bus_rdata,
	// channel status
	output logic [NUM_CH-1:0] enable,
	output logic [NUM_CH-1:0] req_flag,
	output logic [NUM_CH-1:0][CNT_W-1:0] count,
	output logic [NUM_CH-1:0][ADDR_W-1:0] fwd_ptr,
	output logic [NUM_CH-1:0] underflow
);

	initial begin
		if (NUM_CH < 1 || NUM_CH > CH_COUNT) begin
			$error("channel count must be 1 to 4");
		end
	end

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [NUM_CH-1:0] pin_s1, pin_s2, pin_s3;
	logic byte_s1, byte_s2;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_s1 <= '1;
			pin_s2 <= '1;
			pin_s3 <= '1;
			byte_s1 <= 1'b0;
			byte_s2 <= 1'b0;
		end else begin
			pin_s1 <= external_irq_pin;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			byte_s1 <= byte_pin;
			byte_s2 <= byte_s1;
		end
	end

	// ****************************************
	// request selection and arbitration
	// ****************************************
	logic [NUM_CH-1:0] trig;
	logic [CH_W-1:0] grant;
	logic grant_any;

	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			unique case (channel_cause_select[i])
				// same cycle as the peripheral interrupt
				CAUSE_PERIPH: trig[i] = periph_irq[i];
				CAUSE_SOFT: trig[i] = sw_req[i];
				// falling edge of the synchronised pin
				CAUSE_EXT_FALL: trig[i] = pin_s3[i] && !pin_s2[i];
				CAUSE_EXT_BOTH: trig[i] = pin_s3[i] ^ pin_s2[i];
			endcase
		end
		grant = '0;
		grant_any = 1'b0;
		// descending loop so the lowest index wins
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (enable[i] && req_flag[i]) begin
				grant = CH_W'(i);
				grant_any = 1'b1;
			end
		end
	end

	// ****************************************
	// sequencer
	// ****************************************
	seq_state_t state, next_state;
	logic [CH_W-1:0] cur, next_cur;
	logic [NUM_CH-1:0] first, next_first;
	logic [ADDR_W-1:0] src_a, dst_a, next_src_a, next_dst_a;
	logic unit_r, next_unit_r;
	logic part, next_part;
	logic [CYC_W-1:0] cyc, next_cyc;
	logic [BYTE_W-1:0] low_byte, next_low_byte;
	logic narrow, split, last_piece, acc_end;
	logic [CYC_W-1:0] coef;
	logic [ADDR_W-1:0] acc_base;
	logic start, finish;
	logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [DATA_W-1:0] fifo_in_data, fifo_out_data;

	always_comb begin
		narrow = ext_bus_mode && byte_s2;
		acc_base = (state == ST_READ) ? src_a : dst_a;
		// odd word start splits into two accesses
		split = unit_r && (narrow || acc_base[0]);
		last_piece = !split || part;
		// sfr or waited region stretches the access
		// read uses j, write uses k
		if (region_sfr) begin
			coef = COEF_SFR;
		end else if (state == ST_WRITE && region_ext && region_waits == '0) begin
			coef = COEF_EXT_WRITE;
		end else begin
			coef = COEF_BASE + {1'b0, region_waits};
		end
		acc_end = (cyc == coef - CYC_ONE);
		bus_own = (state == ST_READ) || (state == ST_WRITE);
		bus_addr = acc_base + (part ? STEP_BYTE : ADDR_RST);
		bus_rd = (state == ST_READ);
		bus_wr = (state == ST_WRITE) && fifo_out_valid;
		bus_byte = !unit_r || split;
		if (!split) begin
			bus_wdata = fifo_out_data;
		end else if (part) begin
			bus_wdata = {{BYTE_W{1'b0}}, fifo_out_data[DATA_W-1:BYTE_W]};
		end else begin
			bus_wdata = {{BYTE_W{1'b0}}, fifo_out_data[BYTE_W-1:0]};
		end
		if (!unit_r) begin
			fifo_in_data = {{BYTE_W{1'b0}}, bus_rdata[BYTE_W-1:0]};
		end else if (split) begin
			fifo_in_data = {bus_rdata[BYTE_W-1:0], low_byte};
		end else begin
			fifo_in_data = bus_rdata;
		end
		fifo_in_valid = (state == ST_READ) && acc_end && last_piece;
		fifo_out_ready = bus_wr && acc_end && last_piece;
		start = 1'b0;
		finish = 1'b0;
		next_state = state;
		next_cur = cur;
		next_src_a = src_a;
		next_dst_a = dst_a;
		next_unit_r = unit_r;
		next_part = part;
		next_cyc = cyc;
		next_low_byte = low_byte;
		unique case (state)
			ST_IDLE: begin
				if (grant_any) begin
					start = 1'b1;
					next_cur = grant;
					next_unit_r = unit_16[grant];
					if (first[grant] && fwd_is_src[grant]) begin
						next_src_a = src_ptr[grant];
					end else if (fwd_is_src[grant]) begin
						next_src_a = fwd_ptr[grant];
					end else begin
						next_src_a = src_ptr[grant];
					end
					if (first[grant] && !fwd_is_src[grant]) begin
						next_dst_a = dst_ptr[grant];
					end else if (!fwd_is_src[grant]) begin
						next_dst_a = fwd_ptr[grant];
					end else begin
						next_dst_a = dst_ptr[grant];
					end
					next_part = 1'b0;
					next_cyc = '0;
					next_state = ST_READ;
				end
			end
			ST_READ: begin
				if (!acc_end) begin
					next_cyc = cyc + CYC_ONE;
				end else if (!last_piece) begin
					next_low_byte = bus_rdata[BYTE_W-1:0];
					next_part = 1'b1;
					next_cyc = '0;
				end else if (fifo_in_ready) begin
					// full buffer holds the read strobe until space frees
					next_part = 1'b0;
					next_cyc = '0;
					next_state = ST_WRITE;
				end
			end
			ST_WRITE: begin
				if (!fifo_out_valid) begin
					next_cyc = '0;
				end else if (!acc_end) begin
					next_cyc = cyc + CYC_ONE;
				end else if (!last_piece) begin
					next_part = 1'b1;
					next_cyc = '0;
				end else begin
					finish = 1'b1;
					next_part = 1'b0;
					next_cyc = '0;
					// hand the bus back for one CPU access
					next_state = ST_CPU;
				end
			end
			ST_CPU: begin
				if (cpu_access_done) begin
					next_state = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			cur <= '0;
			src_a <= ADDR_RST;
			dst_a <= ADDR_RST;
			unit_r <= 1'b0;
			part <= 1'b0;
			cyc <= '0;
			low_byte <= '0;
		end else begin
			state <= next_state;
			cur <= next_cur;
			src_a <= next_src_a;
			dst_a <= next_dst_a;
			unit_r <= next_unit_r;
			part <= next_part;
			cyc <= next_cyc;
			low_byte <= next_low_byte;
		end
	end

	// ****************************************
	// channel state
	// ****************************************
	logic [NUM_CH-1:0] next_enable, next_req_flag, next_underflow;
	logic [NUM_CH-1:0][CNT_W-1:0] next_count;
	logic [NUM_CH-1:0][ADDR_W-1:0] next_fwd_ptr;

	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			next_enable[i] = enable[i];
			next_first[i] = first[i];
			next_count[i] = count[i];
			next_fwd_ptr[i] = fwd_ptr[i];
			next_underflow[i] = 1'b0;
			next_req_flag[i] = req_flag[i];
			if (req_clear[i]) begin
				next_req_flag[i] = 1'b0;
			end
			// only the granted channel loses its flag
			if (start && grant == CH_W'(i)) begin
				next_req_flag[i] = 1'b0;
			end
			// set regardless of enable, and set wins
			// every channel samples its cause each cycle
			if (trig[i]) begin
				next_req_flag[i] = 1'b1;
			end
			if (start && grant == CH_W'(i) && first[i]) begin
				next_fwd_ptr[i] = fwd_is_src[i] ? src_ptr[i] : dst_ptr[i];
				next_count[i] = count_reload[i];
				next_first[i] = 1'b0;
			end
			if (finish && cur == CH_W'(i)) begin
				next_fwd_ptr[i] = fwd_ptr[i] + (unit_r ? STEP_WORD : STEP_BYTE);
				if (count[i] == CNT_ZERO) begin
					next_underflow[i] = 1'b1;
					if (repeat_mode[i]) begin
						next_fwd_ptr[i] = fwd_is_src[i] ? src_ptr[i] : dst_ptr[i];
						next_count[i] = count_reload[i];
					end else begin
						next_enable[i] = 1'b0;
						next_first[i] = 1'b1;
					end
				end else begin
					next_count[i] = count[i] - CNT_ONE;
				end
			end
			// rewrite while active restarts both reloads
			if (enable_write[i]) begin
				next_enable[i] = enable_wdata[i];
				next_first[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enable <= '0;
			first <= '1;
			req_flag <= '0;
			count <= '0;
			fwd_ptr <= '0;
			underflow <= '0;
		end else begin
			enable <= next_enable;
			first <= next_first;
			req_flag <= next_req_flag;
			count <= next_count;
			fwd_ptr <= next_fwd_ptr;
			underflow <= next_underflow;
		end
	end

	// ****************************************
	// data buffer
	// ****************************************
	dma_unit_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) unit_buffer (
		.clk(clk),
		.rst(rst),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

endmodule

// ### dma_cpu_bus_model.sv
// cpu and memory side model: read data, region decode, cpu access slot
`timescale 1ns/1ps
module dma_cpu_bus_model
	import dma_cycle_pkg::*;
(
	// clock, reset, pace
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	// controller bus
	input wire logic bus_own,
	input wire logic bus_rd,
	input wire logic [ADDR_W-1:0] bus_addr,
	// answers
	output logic [DATA_W-1:0] bus_rdata,
	output logic region_sfr,
	output logic region_ext,
	output logic [1:0] region_waits,
	output logic cpu_access_done
);
	logic [2:0] cpu_cnt;
	logic [DATA_W-1:0] last;

	// ****************************************
	// decode and data
	// ****************************************
	assign region_sfr = bus_addr < 20'h0_0400;
	assign region_ext = bus_addr >= 20'h1_0000;
	assign region_waits = (bus_addr[19:12] == 8'h0A) ? 2'h1 : 2'h0;
	// idle bus shows inverse of last data, never a stale copy
	assign bus_rdata = bus_rd ? {bus_addr[7:0] ^ 8'hA5, bus_addr[7:0]} : ~last;
	// slow mode stretches the cpu access
	assign cpu_access_done = !bus_own && cpu_cnt == (slow ? 3'h5 : 3'h0);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cpu_cnt <= 3'h0;
			last <= 16'h0000;
		end else begin
			cpu_cnt <= (bus_own || cpu_access_done) ? 3'h0 : cpu_cnt + 3'h1;
			if (bus_rd)
				last <= bus_rdata;
		end
	end
endmodule

// ### dma_request_priority_cycle_control_chk.sv
// port-level properties of the transfer controller
`timescale 1ns/1ps
module dma_request_priority_cycle_control_chk
	import dma_cycle_pkg::*;
#(
	parameter int NUM_CH = CH_COUNT
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// stimulus
	input wire logic [NUM_CH-1:0] enable_write,
	input wire logic [NUM_CH-1:0] req_clear,
	input wire logic [NUM_CH-1:0][CAUSE_W-1:0] channel_cause_select,
	input wire logic [NUM_CH-1:0] repeat_mode,
	input wire logic [NUM_CH-1:0][CNT_W-1:0] count_reload,
	input wire logic [NUM_CH-1:0] periph_irq,
	input wire logic [NUM_CH-1:0] sw_req,
	input wire logic region_sfr,
	input wire logic cpu_access_done,
	// observed
	input wire logic bus_own,
	input wire logic bus_rd,
	input wire logic bus_wr,
	input wire logic [NUM_CH-1:0] enable,
	input wire logic [NUM_CH-1:0] req_flag,
	input wire logic [NUM_CH-1:0][CNT_W-1:0] count,
	input wire logic [NUM_CH-1:0] underflow
);
	logic [NUM_CH-1:0] hit;
	logic [NUM_CH-1:0] clr;
	logic slot_ok;
	logic next_slot_ok;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	property p_keep(int k);
		$fell(req_flag[k]) && !$past(req_clear[k]) |-> $rose(bus_own);
	endproperty

	// ****************************************
	// helpers
	// ****************************************
	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		assign hit[i] = (sw_req[i] && channel_cause_select[i] == CAUSE_SOFT) ||
			(periph_irq[i] && channel_cause_select[i] == CAUSE_PERIPH);
		// edge causes left out: their timing is behind the pin synchroniser
		assign clr[i] = req_clear[i] && !hit[i] && !channel_cause_select[i][1];
		a_keep: assert property (p_keep(i)) else $error("flag dropped without start");
	end

	always_comb begin
		next_slot_ok = slot_ok;
		if (bus_own)
			next_slot_ok = 1'b0;
		else if (cpu_access_done)
			next_slot_ok = 1'b1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			slot_ok <= 1'b1;
		else
			slot_ok <= next_slot_ok;
	end

	// ****************************************
	// properties
	// ****************************************
	property p_flag_set;
		|hit |=> (req_flag & $past(hit)) == $past(hit);
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set");
	property p_flag_clr;
		|clr |=> (req_flag & $past(clr)) == '0;
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
	property p_prio;
		$rose(bus_own) && $fell(req_flag[1]) |-> !$past(enable[0] && req_flag[0]);
	endproperty
	a_prio: assert property (p_prio) else $error("channel one beat zero");
	property p_read_first;
		$rose(bus_own) |-> bus_rd && !bus_wr;
	endproperty
	a_read_first: assert property (p_read_first) else $error("no read first");
	property p_write_after;
		$rose(bus_wr) |-> $past(bus_rd) && bus_own;
	endproperty
	a_write_after: assert property (p_write_after) else $error("write not after read");
	property p_slot;
		$rose(bus_own) |-> slot_ok;
	endproperty
	a_slot: assert property (p_slot) else $error("no cpu access between");
	property p_sfr;
		$rose(bus_rd) && region_sfr |-> bus_rd [*2];
	endproperty
	a_sfr: assert property (p_sfr) else $error("short special area read");
	property p_single;
		underflow[0] && !repeat_mode[0] && !enable_write[0] && !$past(enable_write[0])
			|=> !enable[0];
	endproperty
	a_single: assert property (p_single) else $error("single mode kept enable");
	property p_repeat;
		underflow[0] && repeat_mode[0] && !enable_write[0] && !$past(enable_write[0])
			|=> enable[0] && count[0] == count_reload[0];
	endproperty
	a_repeat: assert property (p_repeat) else $error("repeat mode not reloaded");

	c_deferred: cover property ($rose(bus_own) && req_flag[3]);
	c_repeat: cover property (underflow[0] && repeat_mode[0]);
	c_clear: cover property (|clr);
endmodule

bind dma_request_priority_cycle_control dma_request_priority_cycle_control_chk #(
	.NUM_CH(NUM_CH)
) chk (.*);

// ### dma_request_priority_cycle_control_bench.sv
// self-checking bench for the transfer controller
`timescale 1ns/1ps
module dma_request_priority_cycle_control_bench;
	import dma_cycle_pkg::*;
	logic clk, rst, ext_bus_mode, byte_pin, slow, cpu_access_done, rd_q;
	logic [3:0] enable_write, enable_wdata, req_clear, repeat_mode, unit_16, fwd_is_src;
	logic [3:0] periph_irq, sw_req, external_irq_pin, enable, req_flag, underflow;
	logic [3:0][CAUSE_W-1:0] channel_cause_select;
	logic [3:0][ADDR_W-1:0] src_ptr, dst_ptr, fwd_ptr;
	logic [3:0][CNT_W-1:0] count_reload, count;
	logic region_sfr, region_ext, bus_own, bus_rd, bus_wr, bus_byte;
	logic [1:0] region_waits;
	logic [ADDR_W-1:0] bus_addr;
	logic [DATA_W-1:0] bus_wdata, bus_rdata;
	logic [ADDR_W-1:0] order[$];
	int n_mismatch, samples_checked, rd_n, wr_n;
	logic [4:0] cu = 5'h07;
	logic [4:0] cm = 5'h04;
	logic [ADDR_W-1:0] cs[5] = '{20'h0_8000, 20'h0_8001, 20'h0_8000, 20'h0_0300, 20'h0_A000};
	logic [ADDR_W-1:0] cd[5] = '{20'h0_8100, 20'h0_8101, 20'h0_8100, 20'h1_0000, 20'h0_8000};
	logic [3:0] er[5] = '{4'h1, 4'h2, 4'h2, 4'h2, 4'h2};
	logic [3:0] ew[5] = '{4'h1, 4'h2, 4'h2, 4'h2, 4'h1};
	// last write: byte flag and data, from the model's address pattern
	logic [16:0] ed[5] = '{17'h0_A500, 17'h1_0002, 17'h1_0001, 17'h1_0000, 17'h1_0000};
	logic [16:0] wd;

	dma_request_priority_cycle_control DUT (.*);
	dma_cpu_bus_model cpu (.*);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// sample off the launching edge so outputs have settled
	always @(negedge clk) begin
		rd_n += bus_rd;
		wr_n += bus_wr;
		if (bus_wr)
			wd = {bus_byte, bus_wdata};
		if (bus_rd && !rd_q)
			order.push_back(bus_addr);
		rd_q = bus_rd;
	end

	// ****************************************
	// access tasks
	// ****************************************
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic en(input logic [3:0] m, input logic [3:0] v);
		enable_write = m;
		enable_wdata = v;
		tick(1);
		enable_write = 4'h0;
	endtask
	task automatic fire(input logic [3:0] m);
		sw_req = m;
		tick(1);
		sw_req = 4'h0;
	endtask
	task automatic clear(input logic [3:0] m);
		req_clear = m;
		tick(1);
		req_clear = 4'h0;
	endtask
	// bounded wait until bus idle and nothing enabled is pending
	task automatic settle();
		int k;
		k = 0;
		tick(2);
		while ((bus_own || (req_flag & enable) != 4'h0) && k < 500) begin
			tick(1);
			k++;
		end
		if (k == 500)
			chk(1, 0);
		tick(1);
	endtask
	task automatic summarize();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#100000;
		n_mismatch++;
		summarize();
	end

	// ****************************************
	// tests
	// ****************************************
	initial begin
		{rst, external_irq_pin, src_ptr, dst_ptr, fwd_is_src} = '1;
		{ext_bus_mode, byte_pin, slow, enable_write, enable_wdata, req_clear} = '0;
		{repeat_mode, unit_16, periph_irq, sw_req, count_reload, rd_q} = '0;
		channel_cause_select = {CAUSE_SOFT, CAUSE_SOFT, CAUSE_SOFT, CAUSE_PERIPH};
		tick(16);
		rst = 1'b0;
		clear(4'hF);
		sw_req = 4'hF;
		periph_irq = 4'h1;
		tick(1);
		{sw_req, periph_irq} = '0;
		chk(req_flag, 4'hF);
		clear(4'h5);
		chk(req_flag, 4'hA);
		$display("test flags done");
		src_ptr = {20'h0_8300, 20'h0_8200, 20'h0_8100, 20'h0_8000};
		fire(4'h4);
		slow = 1'b1;
		en(4'hE, 4'hE);
		settle();
		chk(order.size(), 3);
		chk(order[0], 20'h0_8100);
		chk(order[1], 20'h0_8200);
		chk(order[2], 20'h0_8300);
		chk({enable, req_flag}, 8'h00);
		$display("test priority done");
		slow = 1'b0;
		channel_cause_select[0] = CAUSE_SOFT;
		count_reload[0] = 16'h0002;
		clear(4'h1);
		en(4'h1, 4'h1);
		repeat (2) begin
			fire(4'h1);
			settle();
			chk(fwd_ptr[0], 20'h0_8001);
			chk(count[0], 16'h0001);
			en(4'h1, 4'h1);
		end
		repeat (3) begin
			fire(4'h1);
			settle();
		end
		chk(enable[0], 1'b0);
		$display("test reload done");
		{repeat_mode[0], fwd_is_src[0], count_reload[0]} = {2'h2, 16'h0000};
		dst_ptr[0] = 20'h0_9400;
		en(4'h1, 4'h1);
		repeat (2) begin
			fire(4'h1);
			settle();
			chk({enable[0], fwd_ptr[0], count[0]}, {1'b1, 20'h0_9400, 16'h0000});
		end
		en(4'h1, 4'h0);
		{repeat_mode[0], fwd_is_src[0]} = 2'h1;
		$display("test repeat done");
		for (int i = 0; i < 5; i++) begin
			{unit_16[0], src_ptr[0], dst_ptr[0]} = {cu[i], cs[i], cd[i]};
			{ext_bus_mode, byte_pin} = {2{cm[i]}};
			tick(4);
			rd_n = 0;
			wr_n = 0;
			en(4'h1, 4'h1);
			fire(4'h1);
			settle();
			chk(rd_n, er[i]);
			chk(wr_n, ew[i]);
			chk(wd, ed[i]);
		end
		$display("test cycles done");
		channel_cause_select[3:2] = {CAUSE_EXT_BOTH, CAUSE_EXT_FALL};
		clear(4'hF);
		external_irq_pin = 4'h3;
		tick(6);
		chk(req_flag, 4'hC);
		clear(4'hF);
		external_irq_pin = 4'hF;
		tick(6);
		chk(req_flag, 4'h8);
		$display("test pins done");
		summarize();
	end
endmodule
